// >>> core/selftest_expanded_regs.sv
// Self-test, expanded-window and port-address management registers behind the serial management pins.
`timescale 1ns/1ps

// How it works
// - Pattern bit picks pseudo-random or fill byte.
// - Receive enable bit starts and stops counting.
// - Counting never disturbs normal traffic.
// - Half select shows low or high counter word.
// - Three-bit quantity decodes to frame count.
// - LED select acts only when LED mode enabled.
// - Reserved bits read zero, host writes zero.
// - Addresses 0x1B and 0x1C do nothing.
// - Data register writes the addressed location and reads it, except write-only mode reads back the last written data word.
// - Byte modes map only the low octet.
// - Pointer register selects the expanded location.
// - Port address loads from strap, stays writable.
// - Count kind picks frames or CRC errors.
// - Access control field selects window mode.
// - Auto-increment advances pointer after each data register access.
// - Broadcast enable also accepts writes to port zero.
module selftest_expanded_regs
    import selftest_regs_pkg::*;
#(
    parameter int WINDOW_DEPTH = 512
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Serial management pins.
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Strap and neighbouring register bits.
    input wire logic [4:0] strap_port_address,
    input wire logic broadcast_enable,
    input wire logic [1:0] window_access_mode,
    input wire logic led_mode_enable,
    // Receive events and transmit self-test engine.
    input wire rx_event_s rx_event,
    input wire logic tx_frame_done,
    output tx_selftest_s tx_selftest,
    // LED steering.
    output logic led_link_activity_select
);

    localparam int AW = $clog2(WINDOW_DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin edge detection.

    logic rst_meta_r;
    logic rst_n_r;
    logic mdc_q_r;
    logic mdc_rise;

    // Reset is applied at once and released through two flip-flops.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // The management clock is sampled as a plain input.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mdc_q_r <= 1'b0;
        end else begin
            mdc_q_r <= mdc;
        end
    end

    assign mdc_rise = mdc & ~mdc_q_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state declarations.

    logic [15:0] cfg1_r;
    logic [15:0] cfg2_r;
    logic [15:0] win_data_r;
    logic [15:0] win_ptr_r;
    logic [4:0] port_addr_r;
    logic strap_taken_r;
    logic [31:0] rx_count_r;
    logic [23:0] tx_count_r;
    logic [7:0] window_mem [WINDOW_DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // Serial management frame receiver.

    frame_state_e state_r;
    logic [5:0] pre_cnt_r;
    logic [4:0] bit_cnt_r;
    logic [12:0] hdr_r;
    logic [15:0] shift_r;
    logic is_read_r;
    logic [4:0] reg_addr_r;
    logic out_r;
    logic oe_r;
    logic wr_go_r;
    logic rd_go_r;

    logic [12:0] hdr_full;
    logic hdr_done;
    logic hdr_is_read;
    logic hdr_is_write;
    logic port_hit_read;
    logic port_hit_write;
    logic frame_accept;
    logic [15:0] read_value;

    // The header is complete once thirteen bits after the start zero are in.
    assign hdr_full = {hdr_r[11:0], mdio_in};
    assign hdr_done = (bit_cnt_r == 5'(HEADER_BITS - 4'd1));
    assign hdr_is_read = hdr_full[12] && (hdr_full[11:10] == OP_READ);
    assign hdr_is_write = hdr_full[12] && (hdr_full[11:10] == OP_WRITE);
    assign port_hit_read = (hdr_full[9:5] == port_addr_r);
    assign port_hit_write = port_hit_read || (broadcast_enable && hdr_full[9:5] == BROADCAST_PORT);
    assign frame_accept = (hdr_is_read && port_hit_read) || (hdr_is_write && port_hit_write);

    // Frame walker: preamble, header, turnaround, data; one step per management clock rise.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_PREAMBLE;
            pre_cnt_r <= 6'd0;
            bit_cnt_r <= 5'd0;
            hdr_r <= 13'd0;
            shift_r <= 16'h0000;
            is_read_r <= 1'b0;
            reg_addr_r <= 5'h00;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            wr_go_r <= 1'b0;
            rd_go_r <= 1'b0;
        end else begin
            wr_go_r <= 1'b0;
            rd_go_r <= 1'b0;
            if (mdc_rise) begin
                unique case (state_r)
                    ST_PREAMBLE: begin
                        if (mdio_in) begin
                            pre_cnt_r <= (pre_cnt_r == PREAMBLE_BITS) ? pre_cnt_r : pre_cnt_r + 6'd1;
                        end else if (pre_cnt_r == PREAMBLE_BITS) begin
                            state_r <= ST_HEADER;
                            bit_cnt_r <= 5'd0;
                        end else begin
                            pre_cnt_r <= 6'd0;
                        end
                    end
                    ST_HEADER: begin
                        hdr_r <= hdr_full;
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        if (hdr_done) begin
                            pre_cnt_r <= 6'd0;
                            bit_cnt_r <= 5'd0;
                            reg_addr_r <= hdr_full[4:0];
                            is_read_r <= hdr_is_read;
                            state_r <= frame_accept ? ST_TURN : ST_PREAMBLE;
                            rd_go_r <= frame_accept && hdr_is_read;
                            shift_r <= read_value;
                        end
                    end
                    ST_TURN: begin
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        oe_r <= is_read_r;
                        out_r <= (bit_cnt_r == 5'd0) ? 1'b0 : shift_r[15];
                        if (bit_cnt_r == 5'd1) begin
                            state_r <= ST_DATA;
                            bit_cnt_r <= 5'd0;
                        end
                    end
                    ST_DATA: begin
                        bit_cnt_r <= bit_cnt_r + 5'd1;
                        shift_r <= {shift_r[14:0], mdio_in};
                        out_r <= shift_r[14];
                        if (bit_cnt_r == 5'(DATA_BITS - 5'd1)) begin
                            state_r <= ST_PREAMBLE;
                            oe_r <= 1'b0;
                            wr_go_r <= ~is_read_r;
                        end
                    end
                endcase
            end
        end
    end

    assign mdio_out = out_r;
    assign mdio_oe = oe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding of accesses and window behaviour.

    logic wr_cfg1;
    logic wr_cfg2;
    logic wr_data;
    logic wr_ptr;
    logic wr_port;
    logic rd_data;
    logic mode_incr;
    logic mode_word;
    logic [AW-1:0] idx_lo;
    logic [AW-1:0] idx_hi;
    logic [15:0] mem_word;
    logic [15:0] counter_half;

    // Addresses 0x1B and 0x1C decode to nothing and read as zero.
    assign wr_cfg1 = wr_go_r && reg_addr_r == ADDR_CONFIG_ONE;
    assign wr_cfg2 = wr_go_r && reg_addr_r == ADDR_CONFIG_TWO;
    assign wr_data = wr_go_r && reg_addr_r == ADDR_WINDOW_DATA;
    assign wr_ptr = wr_go_r && reg_addr_r == ADDR_WINDOW_POINTER;
    assign wr_port = wr_go_r && reg_addr_r == ADDR_PORT_ADDRESS;
    assign rd_data = rd_go_r && reg_addr_r == ADDR_WINDOW_DATA;

    // Mode field picks byte or word width and whether the pointer advances.
    assign mode_incr = (window_access_mode == MODE_BYTE_INCR) || (window_access_mode == MODE_WORD_INCR);
    assign mode_word = (window_access_mode == MODE_WORD_INCR);
    assign idx_lo = win_ptr_r[AW-1:0];
    assign idx_hi = AW'(win_ptr_r[AW-1:0] + 1'b1);
    assign mem_word = mode_word ? {window_mem[idx_hi], window_mem[idx_lo]} : {8'h00, window_mem[idx_lo]};
    assign counter_half = cfg2_r[CFG2_HALF_SELECT] ? rx_count_r[31:16] : rx_count_r[15:0];

    // Read multiplexer; reserved bits are never stored, so they return zero.
    always_comb begin
        unique case (hdr_full[4:0])
            ADDR_COUNTER_READ: read_value = counter_half;
            ADDR_CONFIG_ONE: read_value = cfg1_r;
            ADDR_CONFIG_TWO: read_value = cfg2_r;
            ADDR_WINDOW_DATA: read_value = (window_access_mode == MODE_BYTE_WRITE_ONLY) ? win_data_r : mem_word;
            ADDR_WINDOW_POINTER: read_value = win_ptr_r;
            ADDR_PORT_ADDRESS: read_value = {11'h000, port_addr_r};
            default: read_value = 16'h0000;
        endcase
    end

    // Expanded storage; byte modes touch only the low octet.
    always_ff @(posedge clk) begin
        if (wr_data) begin
            window_mem[idx_lo] <= wr_payload_lo(shift_r);
            if (mode_word) begin
                window_mem[idx_hi] <= shift_r[15:8];
            end
        end
    end

    function automatic logic [7:0] wr_payload_lo(input logic [15:0] word);
        return word[7:0];
    endfunction

    // Data holder and pointer; the pointer advances after each data access when enabled.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            win_data_r <= WINDOW_DATA_RESET;
            win_ptr_r <= WINDOW_POINTER_RESET;
        end else begin
            if (wr_data) begin
                win_data_r <= shift_r;
            end
            if (wr_ptr) begin
                win_ptr_r <= shift_r;
            end else if ((wr_data || rd_data) && mode_incr) begin
                win_ptr_r <= win_ptr_r + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port address, loaded from the strap just after reset release.

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            port_addr_r <= PORT_STRAP_DEFAULT;
            strap_taken_r <= 1'b0;
        end else begin
            strap_taken_r <= 1'b1;
            if (!strap_taken_r) begin
                port_addr_r <= strap_port_address;
            end else if (wr_port) begin
                port_addr_r <= shift_r[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers and transmit frame quantity.

    logic [23:0] qty_target;
    logic tx_finite;
    logic tx_last;

    assign qty_target = FRAME_QTY[cfg2_r[CFG2_QTY_HI:CFG2_QTY_LO]];
    assign tx_finite = (cfg2_r[CFG2_QTY_HI:CFG2_QTY_LO] != 3'b000);
    assign tx_last = cfg1_r[CFG1_TX_START] && tx_finite && tx_frame_done && (tx_count_r + 24'd1 == qty_target);

    // Start bit self-clears after the last frame; the clear bit always self-clears.
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg1_r <= CONFIG_RESET;
            cfg2_r <= CONFIG_RESET;
            tx_count_r <= 24'd0;
        end else begin
            if (wr_cfg1) begin
                cfg1_r <= shift_r & CFG1_STORE_MASK;
                tx_count_r <= 24'd0;
            end else begin
                cfg1_r[CFG1_COUNT_CLEAR] <= 1'b0;
                if (tx_last) begin
                    cfg1_r[CFG1_TX_START] <= 1'b0;
                end
                if (cfg1_r[CFG1_TX_START] && tx_frame_done) begin
                    tx_count_r <= tx_count_r + 24'd1;
                end
            end
            if (wr_cfg2) begin
                cfg2_r <= shift_r & CFG2_STORE_MASK;
            end
        end
    end

    // Engine settings come straight from the stored fields.
    assign tx_selftest = '{run: cfg1_r[CFG1_TX_START],
                           pseudo_random_nine_pattern: cfg1_r[CFG1_PATTERN_KIND],
                           fill_byte: cfg1_r[7:0],
                           long_frame: cfg1_r[CFG1_LONG_FRAME],
                           long_gap: cfg1_r[CFG1_LONG_GAP]};
    assign led_link_activity_select = led_mode_enable & cfg2_r[CFG2_LED_SELECT];

    ////////////////////////////////////////////////////////////////////////////////
    // Receive event counter; it only observes events and feeds nothing back.

    logic rx_hit;

    assign rx_hit = cfg1_r[CFG1_COUNT_KIND] ? rx_event.crc_error : rx_event.frame;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_count_r <= 32'h0000_0000;
        end else if (cfg1_r[CFG1_COUNT_CLEAR]) begin
            rx_count_r <= 32'h0000_0000;
        end else if (cfg2_r[CFG2_RX_ENABLE] && rx_hit) begin
            rx_count_r <= rx_count_r + 32'h0000_0001;
        end
    end

endmodule

// >>> core/selftest_regs_pkg.sv
// Package with offsets, field positions, reset values and shared types of the self-test register slice.
package selftest_regs_pkg;

    // Management register addresses.
    localparam logic [4:0] ADDR_COUNTER_READ = 5'h18;
    localparam logic [4:0] ADDR_CONFIG_ONE = 5'h19;
    localparam logic [4:0] ADDR_CONFIG_TWO = 5'h1A;
    localparam logic [4:0] ADDR_RESERVED_A = 5'h1B;
    localparam logic [4:0] ADDR_RESERVED_B = 5'h1C;
    localparam logic [4:0] ADDR_WINDOW_DATA = 5'h1D;
    localparam logic [4:0] ADDR_WINDOW_POINTER = 5'h1E;
    localparam logic [4:0] ADDR_PORT_ADDRESS = 5'h1F;
    localparam logic [4:0] BROADCAST_PORT = 5'h00;

    // Field positions in the first configuration register.
    localparam int CFG1_COUNT_KIND = 15;
    localparam int CFG1_COUNT_CLEAR = 14;
    localparam int CFG1_LONG_FRAME = 13;
    localparam int CFG1_LONG_GAP = 12;
    localparam int CFG1_TX_START = 11;
    localparam int CFG1_PATTERN_KIND = 10;

    // Field positions in the second configuration register.
    localparam int CFG2_RX_ENABLE = 15;
    localparam int CFG2_HALF_SELECT = 14;
    localparam int CFG2_QTY_HI = 13;
    localparam int CFG2_QTY_LO = 11;
    localparam int CFG2_LED_SELECT = 0;

    // Writable masks; reserved bits are never stored and read as zero.
    localparam logic [15:0] CFG1_STORE_MASK = 16'hFCFF;
    localparam logic [15:0] CFG2_STORE_MASK = 16'hF801;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_DATA_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_POINTER_RESET = 16'h0000;
    localparam logic [4:0] PORT_STRAP_DEFAULT = 5'h01;

    // Expanded access modes.
    localparam logic [1:0] MODE_BYTE_FIXED = 2'b00;
    localparam logic [1:0] MODE_BYTE_INCR = 2'b01;
    localparam logic [1:0] MODE_WORD_INCR = 2'b10;
    localparam logic [1:0] MODE_BYTE_WRITE_ONLY = 2'b11;

    // Serial management frame constants.
    localparam logic [5:0] PREAMBLE_BITS = 6'd32;
    localparam logic [3:0] HEADER_BITS = 4'd13;
    localparam logic [4:0] DATA_BITS = 5'd16;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;

    // Frame quantities; code zero means continuous transmission.
    localparam logic [23:0] FRAME_QTY [0:7] = '{24'd0, 24'd1, 24'd10, 24'd100, 24'd1000, 24'd10000,
                                                24'd100000, 24'd10000000};

    // Settings handed to the transmit self-test engine.
    typedef struct packed {
        logic run;
        logic pseudo_random_nine_pattern;
        logic [7:0] fill_byte;
        logic long_frame;
        logic long_gap;
    } tx_selftest_s;

    // Receive events offered to the counter.
    typedef struct packed {
        logic frame;
        logic crc_error;
    } rx_event_s;

    // Frame receiver states.
    typedef enum logic [3:0] {
        ST_PREAMBLE = 4'b0001,
        ST_HEADER = 4'b0010,
        ST_TURN = 4'b0100,
        ST_DATA = 4'b1000
    } frame_state_e;

endpackage

// >>> tb/selftest_regs_assertions.sv
// Concurrent checks on the ports of the self-test register slice.
`timescale 1ns/1ps
module selftest_regs_checker
    import selftest_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Management pins.
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    // Self-test and LED.
    input wire logic led_mode_enable,
    input wire logic led_link_activity_select,
    input wire logic tx_frame_done,
    input wire tx_selftest_s tx_selftest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic mdc_r;
    logic [2:0] rise_r;
    logic [4:0] rises_r;

    // Track mdc rises and count them while the device drives the line.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mdc_r <= 1'b0;
            rise_r <= 3'h0;
            rises_r <= 5'h00;
        end else begin
            mdc_r <= mdc;
            rise_r <= {rise_r[1:0], mdc & ~mdc_r};
            rises_r <= mdio_oe ? rises_r + 5'(mdc & ~mdc_r) : 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Properties.
    property p_led_gate;
        led_link_activity_select |-> led_mode_enable;
    endproperty
    a_led_gate: assert property (p_led_gate) else $error("led select on while led mode off");
    property p_led_cause;
        $changed(led_link_activity_select) |-> $changed(led_mode_enable) || rise_r[1] || rise_r[2];
    endproperty
    a_led_cause: assert property (p_led_cause) else $error("led select moved without cause");
    property p_oe_len;
        $fell(mdio_oe) |-> rises_r == 5'd17;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("read answer has wrong length");
    property p_oe_start;
        $rose(mdio_oe) |-> !mdio_out;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("turnaround not driven low");
    property p_out_step;
        $changed(mdio_out) |-> rise_r[0] || rise_r[1];
    endproperty
    a_out_step: assert property (p_out_step) else $error("read data moved between mdc rises");
    property p_oe_step;
        $changed(mdio_oe) |-> rise_r[0] || rise_r[1];
    endproperty
    a_oe_step: assert property (p_oe_step) else $error("output enable moved between mdc rises");
    property p_cfg_write;
        $changed(tx_selftest) && !$fell(tx_selftest.run) |-> rise_r[1] || rise_r[2];
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("self-test settings moved without write");
    property p_run_stop;
        $fell(tx_selftest.run) |-> $past(tx_frame_done) || $past(tx_frame_done, 2) || rise_r[1] || rise_r[2];
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("transmit stopped without frame or write");

    // Main scenarios.
    c_read: cover property ($fell(mdio_oe));
    c_run: cover property ($fell(tx_selftest.run));
    c_led: cover property (led_link_activity_select);
endmodule

bind selftest_expanded_regs selftest_regs_checker u_chk (.clk(clk), .reset_n(reset_n), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .led_mode_enable(led_mode_enable),
    .led_link_activity_select(led_link_activity_select), .tx_frame_done(tx_frame_done),
    .tx_selftest(tx_selftest));

// >>> tb/mgmt_host_model.sv
// Station management host that runs serial management frames.
`timescale 1ns/1ps
module mgmt_host_model
    import selftest_regs_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Management pins.
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic host_oe = 1'b0;
    logic host_bit = 1'b1;

    // Line level; the pull-up wins when nobody drives.
    assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);

    initial mdc = 1'b0;

    // One frame; mdc stays low between frames and each phase lasts two clocks.
    task automatic xfer(input logic [1:0] op, input logic [4:0] port, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'b01, op, port, ra, 2'b10, wd};
        rdat = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            host_oe <= !(op == OP_READ && i < 18);
            host_bit <= bits[i];
            mdc <= 1'b0;
            repeat (2) @(posedge clk);
            if (i < 16) rdat = {rdat[14:0], mdio_in};
            mdc <= 1'b1;
            repeat (2) @(posedge clk);
        end
        mdc <= 1'b0;
        host_oe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench for the self-test register slice.
`timescale 1ns/1ps
module tb_top;
    import selftest_regs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic mdc, mdio_in, mdio_out, mdio_oe, led_sel;
    logic [4:0] strap = 5'h05;
    logic bcast = 1'b0;
    logic [1:0] mode = 2'b00;
    logic led_en = 1'b0;
    rx_event_s rx_ev = '0;
    logic done = 1'b0;
    tx_selftest_s tx;
    logic [4:0] port = 5'h05;
    logic [15:0] v;
    int num_errors = 0;
    int n_checks = 0;
    int n;

    always #4 clk = ~clk;

    selftest_expanded_regs #(.WINDOW_DEPTH(16)) u_dut (.clk(clk), .reset_n(reset_n), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strap_port_address(strap),
        .broadcast_enable(bcast), .window_access_mode(mode), .led_mode_enable(led_en), .rx_event(rx_ev),
        .tx_frame_done(done), .tx_selftest(tx), .led_link_activity_select(led_sel));
    mgmt_host_model u_host (.clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_host.xfer(OP_WRITE, port, a, d, v);
    endtask
    task automatic rd(input string w, input logic [4:0] a, input logic [15:0] e);
        u_host.xfer(OP_READ, port, a, 16'h0000, v);
        check(w, v, e);
    endtask
    task automatic pulse(input logic f, input logic c, input logic d, input int k);
        repeat (k) begin
            rx_ev <= '{frame: f, crc_error: c};
            done <= d;
            @(posedge clk);
            rx_ev <= '0;
            done <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        rd("port", ADDR_PORT_ADDRESS, 16'h0005);
        rd("cfg2", ADDR_CONFIG_TWO, 16'h0000);
        rd("data", ADDR_WINDOW_DATA, 16'h0000);
        rd("count", ADDR_COUNTER_READ, 16'h0000);
        wr(ADDR_PORT_ADDRESS, 16'h0003);
        rd("old port", ADDR_PORT_ADDRESS, 16'hFFFF);
        port = 5'h03;
        rd("new port", ADDR_PORT_ADDRESS, 16'h0003);
        bcast <= 1'b1;
        port = 5'h00;
        wr(ADDR_CONFIG_ONE, 16'h04A5);
        rd("port zero read", ADDR_CONFIG_ONE, 16'hFFFF);
        bcast <= 1'b0;
        wr(ADDR_CONFIG_ONE, 16'h0000);
        port = 5'h03;
        rd("cfg1", ADDR_CONFIG_ONE, 16'h04A5);
        check("pattern", {8'h00, tx.pseudo_random_nine_pattern, tx.fill_byte[6:0]}, 16'h00A5);
        wr(ADDR_CONFIG_ONE, 16'h3042);
        check("fill", {5'h00, tx.long_frame, tx.long_gap, tx.pseudo_random_nine_pattern, tx.fill_byte}, 16'h0642);
        $display("test ports and pattern done");
        wr(ADDR_CONFIG_TWO, 16'h07FF);
        rd("cfg2 reserved", ADDR_CONFIG_TWO, 16'h0001);
        check("led off", {15'h0000, led_sel}, 16'h0000);
        led_en <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check("led on", {15'h0000, led_sel}, 16'h0001);
        wr(ADDR_CONFIG_TWO, 16'h0000);
        check("led combined", {15'h0000, led_sel}, 16'h0000);
        for (int a = 27; a < 29; a++) begin
            wr(5'(a), 16'hFFFF);
            rd("reserved reg", 5'(a), 16'h0000);
        end
        $display("test reserved and led done");
        wr(ADDR_CONFIG_TWO, 16'h8000);
        pulse(1'b1, 1'b0, 1'b0, 3);
        pulse(1'b0, 1'b1, 1'b0, 2);
        rd("frames", ADDR_COUNTER_READ, 16'h0003);
        wr(ADDR_CONFIG_TWO, 16'h0000);
        pulse(1'b1, 1'b0, 1'b0, 2);
        rd("held", ADDR_COUNTER_READ, 16'h0003);
        wr(ADDR_CONFIG_TWO, 16'h4000);
        rd("upper half", ADDR_COUNTER_READ, 16'h0000);
        wr(ADDR_CONFIG_ONE, 16'hC000);
        wr(ADDR_CONFIG_TWO, 16'h8000);
        pulse(1'b1, 1'b1, 1'b0, 2);
        pulse(1'b1, 1'b0, 1'b0, 1);
        rd("crc errors", ADDR_COUNTER_READ, 16'h0002);
        $display("test counter done");
        wr(ADDR_WINDOW_POINTER, 16'h0004);
        wr(ADDR_WINDOW_DATA, 16'h12AB);
        rd("byte data", ADDR_WINDOW_DATA, 16'h00AB);
        rd("fixed ptr", ADDR_WINDOW_POINTER, 16'h0004);
        mode <= MODE_BYTE_INCR;
        wr(ADDR_WINDOW_POINTER, 16'h0008);
        wr(ADDR_WINDOW_DATA, 16'h0011);
        wr(ADDR_WINDOW_DATA, 16'h0022);
        rd("incr ptr", ADDR_WINDOW_POINTER, 16'h000A);
        wr(ADDR_WINDOW_POINTER, 16'h0008);
        rd("byte one", ADDR_WINDOW_DATA, 16'h0011);
        rd("byte two", ADDR_WINDOW_DATA, 16'h0022);
        mode <= MODE_WORD_INCR;
        wr(ADDR_WINDOW_POINTER, 16'h000C);
        wr(ADDR_WINDOW_DATA, 16'hBEEF);
        rd("word ptr", ADDR_WINDOW_POINTER, 16'h000D);
        wr(ADDR_WINDOW_POINTER, 16'h000C);
        rd("word data", ADDR_WINDOW_DATA, 16'hBEEF);
        mode <= MODE_BYTE_WRITE_ONLY;
        wr(ADDR_WINDOW_POINTER, 16'h0004);
        wr(ADDR_WINDOW_DATA, 16'h1255);
        rd("wo ptr", ADDR_WINDOW_POINTER, 16'h0004);
        rd("wo data", ADDR_WINDOW_DATA, 16'h1255);
        mode <= MODE_BYTE_FIXED;
        rd("wo stored", ADDR_WINDOW_DATA, 16'h0055);
        wr(ADDR_WINDOW_POINTER, 16'h1234);
        rd("ptr width", ADDR_WINDOW_POINTER, 16'h1234);
        $display("test window done");
        for (int c = 1; c < 3; c++) begin
            wr(ADDR_CONFIG_TWO, 16'(c) << 11);
            wr(ADDR_CONFIG_ONE, 16'h0800);
            n = 0;
            while (tx.run === 1'b1 && n < 20) begin
                pulse(1'b0, 1'b0, 1'b1, 1);
                n++;
            end
            check("frame count", 16'(n), c == 1 ? 16'd1 : 16'd10);
        end
        wr(ADDR_CONFIG_TWO, 16'h0000);
        wr(ADDR_CONFIG_ONE, 16'h0800);
        pulse(1'b0, 1'b0, 1'b1, 12);
        check("continuous", {15'h0000, tx.run}, 16'h0001);
        wr(ADDR_CONFIG_ONE, 16'h0000);
        check("stopped", {15'h0000, tx.run}, 16'h0000);
        $display("test transmit done");
        tally_and_finish();
    end
endmodule
